/* cabin_light_pkg.sv */
package cabin_light_pkg;
	// time base: 1 ms tick from the 50 MHz clock
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned TICK_MS         = 1;
	localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	// lamp periods, printed units
	localparam int unsigned DOOR_OPEN_MIN   = 30;
	localparam int unsigned UNLOCK_S        = 30;
	localparam int unsigned KEY_OUT_S       = 15;
	localparam int unsigned DOOR_CLOSE_S    = 15;
	localparam int unsigned KEY_SLOT_OFF_S  = 15;
	localparam int unsigned KEY_SLOT_MAX_MIN = 30;
	// periods in ticks
	localparam int unsigned DOOR_OPEN_TICKS = DOOR_OPEN_MIN * 60_000 / TICK_MS;
	localparam int unsigned UNLOCK_TICKS    = UNLOCK_S * 1000 / TICK_MS;
	localparam int unsigned KEY_OUT_TICKS   = KEY_OUT_S * 1000 / TICK_MS;
	localparam int unsigned DOOR_CLOSE_TICKS = DOOR_CLOSE_S * 1000 / TICK_MS;
	localparam int unsigned SLOT_OFF_TICKS  = KEY_SLOT_OFF_S * 1000 / TICK_MS;
	localparam int unsigned SLOT_MAX_TICKS  = KEY_SLOT_MAX_MIN * 60_000 / TICK_MS;
	// brightness in percent, then debounce length in ticks and timer width in bits
	localparam logic [6:0]  BRIGHT_FULL     = 7'h64;
	localparam logic [6:0]  BRIGHT_DIM      = 7'h3c;
	localparam int unsigned DEBOUNCE_TICKS  = 20;
	localparam int unsigned TIMER_W         = 21;

	typedef enum logic [4:0] {
		LAMP_OFF       = 5'h01,
		LAMP_DOOR_OPEN = 5'h02,
		LAMP_EXPIRED   = 5'h04,
		LAMP_TIMED     = 5'h08,
		LAMP_REARM     = 5'h10
	} lamp_state_t;
endpackage : cabin_light_pkg

/* cabin_light_timer_control.sv */
`timescale 1ns/1ps
`default_nettype none
module cabin_light_timer_control #(
	parameter int unsigned TICK_DIV   = cabin_light_pkg::TICK_CYCLES,
	parameter int unsigned DOOR_COUNT = 5
) (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	// switch inputs, high = active
	input  wire logic                  ignition_on_i,
	input  wire logic [DOOR_COUNT-1:0] door_open_i,
	input  wire logic                  key_inserted_i,
	input  wire logic                  knob_unlocked_i,
	input  wire logic                  keyless_lock_i,
	input  wire logic                  parking_lamp_state_i,
	// lamp outputs
	output logic                       cabin_lamp_o,
	output logic [6:0]                 cabin_level_o,
	output logic                       key_slot_lamp_o,
	output logic                       indirect_lamp_o
);
	import cabin_light_pkg::*;

	// door 0 is the driver door, the top door is the liftgate
	localparam int unsigned SW_W = DOOR_COUNT + 4;
	// parameter limits: prescaler is 20 bits, liftgate needs a second door
	if (DOOR_COUNT < 2 || TICK_DIV < 2 || TICK_DIV > 1_000_000) begin : g_bad_param
		$error("bad parameter");
	end

	function automatic logic [TIMER_W-1:0] ticks(input int unsigned n);
		ticks = TIMER_W'(n);
	endfunction : ticks

	// prescaler tick
	logic [19:0] pre_cnt;
	wire         tick = (pre_cnt == 20'(TICK_DIV - 1));
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || tick) pre_cnt <= '0;
		else pre_cnt <= pre_cnt + 20'h00001;
	end

	// cabin lamp triggers held off until the debouncers settle after reset, so a switch resting high is no edge for them; key slot edges are not held off
	logic [5:0] arm_cnt;
	wire        armed = (arm_cnt == 6'(2 * DEBOUNCE_TICKS));
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) arm_cnt <= '0;
		else if (tick && !armed) arm_cnt <= arm_cnt + 6'h01;
	end

	// two-stage sync and tick-sampled debounce
	wire  [SW_W-1:0] raw = {parking_lamp_state_i, knob_unlocked_i, key_inserted_i, ignition_on_i, door_open_i};
	logic [SW_W-1:0] sync1, sync2, clean;
	logic [4:0]      db_cnt [SW_W];
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end
	// one process drives all debounce state, one counter per switch
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < SW_W; i++) db_cnt[i] <= '0;
			clean <= '0;
		end else begin
			for (int i = 0; i < SW_W; i++) begin
				if (sync2[i] == clean[i]) begin
					db_cnt[i] <= '0;
				end else if (tick) begin
					if (db_cnt[i] == 5'(DEBOUNCE_TICKS - 1)) begin
						clean[i]  <= sync2[i];
						db_cnt[i] <= '0;
					end else db_cnt[i] <= db_cnt[i] + 5'h01;
				end
			end
		end
	end
	// keyless lock is a command pulse; only synchronised
	logic kl_s1, kl_s2, kl_prev;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			kl_s1   <= 1'b0;
			kl_s2   <= 1'b0;
			kl_prev <= 1'b0;
		end else begin
			kl_s1   <= keyless_lock_i;
			kl_s2   <= kl_s1;
			kl_prev <= kl_s2;
		end
	end

	// decoded conditions and edges
	logic [SW_W-1:0] prev;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) prev <= '0;
		else prev <= clean;
	end
	wire [DOOR_COUNT-1:0] doors      = clean[DOOR_COUNT-1:0];
	wire                  ign_on     = clean[DOOR_COUNT];
	wire                  key_in     = clean[DOOR_COUNT+1];
	wire                  unlocked   = clean[DOOR_COUNT+2];
	wire                  park_on    = clean[DOOR_COUNT+3];
	wire                  any_open   = |doors;
	wire                  was_open   = |prev[DOOR_COUNT-1:0];
	wire                  ign_was    = prev[DOOR_COUNT];
	wire                  main_open  = |doors[DOOR_COUNT-2:0];
	wire                  door_opens = armed & (|(doors & ~prev[DOOR_COUNT-1:0]));
	wire                  ign_rise   = armed & ign_on & ~ign_was;
	wire                  unlock_ev  = armed & unlocked & ~prev[DOOR_COUNT+2] & ~was_open
	                                   & ~key_in & ~prev[DOOR_COUNT+1];
	wire                  keyout_ev  = armed & ~key_in & prev[DOOR_COUNT+1] & ~was_open & ~any_open;
	wire                  close_ev   = armed & ~any_open & was_open & ~ign_was & unlocked;
	wire                  kl_lock    = kl_s2 & ~kl_prev;

	// cabin lamp state machine
	lamp_state_t          state, next_state;
	logic [TIMER_W-1:0]   tmr, next_tmr;
	logic [6:0]           level, next_level;
	wire                  expired = (tmr == '0);
	always_comb begin
		next_state = state;
		next_tmr   = (tick && !expired) ? tmr - 1'b1 : tmr;
		next_level = level;
		case (state)
			LAMP_OFF, LAMP_TIMED: begin
				if (state == LAMP_TIMED && (ign_on || door_opens || !unlocked || expired)) begin
					next_state = LAMP_OFF;
				end
				if (!ign_on && door_opens && !was_open) begin
					next_state = LAMP_DOOR_OPEN;
					next_tmr   = ticks(DOOR_OPEN_TICKS);
					next_level = BRIGHT_FULL;
				end else if (unlock_ev) begin
					next_state = LAMP_TIMED;
					next_tmr   = ticks(UNLOCK_TICKS);
					next_level = BRIGHT_FULL;
				end else if (keyout_ev) begin
					next_state = LAMP_TIMED;
					next_tmr   = ticks(KEY_OUT_TICKS);
					next_level = BRIGHT_FULL;
				end else if (close_ev) begin
					next_state = LAMP_TIMED;
					next_tmr   = ticks(DOOR_CLOSE_TICKS);
					next_level = BRIGHT_DIM;
				end
			end
			LAMP_DOOR_OPEN: begin
				if (!main_open && close_ev) begin
					next_state = LAMP_TIMED;
					next_tmr   = ticks(DOOR_CLOSE_TICKS);
					next_level = BRIGHT_DIM;
				end else if (!main_open) next_state = LAMP_OFF;
				else if (expired) next_state = LAMP_EXPIRED;
			end
			LAMP_EXPIRED: begin
				if (!any_open) next_state = LAMP_REARM;
			end
			LAMP_REARM: begin
				if (door_opens || ign_rise) begin
					next_state = LAMP_DOOR_OPEN;
					next_tmr   = ticks(DOOR_OPEN_TICKS);
					next_level = BRIGHT_FULL;
				end
			end
			default: next_state = LAMP_OFF;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= LAMP_OFF;
			tmr   <= '0;
			level <= '0;
		end else begin
			state <= next_state;
			tmr   <= next_tmr;
			level <= next_level;
		end
	end
	wire lamp_lit = (state == LAMP_DOOR_OPEN) || (state == LAMP_TIMED);

	// pwm, 100 steps per period
	logic [6:0] pwm_cnt;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || pwm_cnt == 7'h63) pwm_cnt <= '0;
		else pwm_cnt <= pwm_cnt + 7'h01;
	end

	// key slot illumination
	logic                 slot_on;
	logic [TIMER_W-1:0]   slot_close_tmr, slot_open_tmr;
	wire                  drv_open = doors[0];
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			slot_on        <= 1'b0;
			slot_close_tmr <= '0;
			slot_open_tmr  <= '0;
		end else begin
			if (drv_open && !prev[0]) slot_open_tmr <= ticks(SLOT_MAX_TICKS);
			else if (tick && slot_open_tmr != '0) slot_open_tmr <= slot_open_tmr - 1'b1;
			if (!drv_open && prev[0]) slot_close_tmr <= ticks(SLOT_OFF_TICKS);
			else if (tick && slot_close_tmr != '0) slot_close_tmr <= slot_close_tmr - 1'b1;
			if (ign_on) slot_on <= 1'b0;
			else if (kl_lock && !any_open) slot_on <= 1'b0;
			else if (drv_open && !prev[0]) slot_on <= 1'b1;
			else if (drv_open && slot_open_tmr == '0) slot_on <= 1'b0;
			else if (drv_open) slot_on <= 1'b1;
			else if (!drv_open && !prev[0] && slot_close_tmr == '0) slot_on <= 1'b0;
		end
	end

	// registered lamp outputs
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cabin_lamp_o    <= 1'b0;
			cabin_level_o   <= '0;
			key_slot_lamp_o <= 1'b0;
			indirect_lamp_o <= 1'b0;
		end else begin
			cabin_lamp_o    <= lamp_lit && (pwm_cnt < level);
			cabin_level_o   <= lamp_lit ? level : 7'h00;
			key_slot_lamp_o <= slot_on;
			indirect_lamp_o <= park_on;
		end
	end

	// checks
	a_indirect_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		park_on |=> indirect_lamp_o) else $error("indirect lamp not following");
	a_slot_ign_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ign_on |=> !slot_on) else $error("key slot lit with ignition on");
	a_dim_close: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(close_ev && (state == LAMP_OFF || state == LAMP_DOOR_OPEN || state == LAMP_TIMED)) |=> level == BRIGHT_DIM)
		else $error("door close not dim");
	a_timed_cancel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state == LAMP_TIMED && ign_on) |=> state != LAMP_TIMED) else $error("timed lamp not cancelled");
	a_open_ends: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state == LAMP_DOOR_OPEN && !main_open && !close_ev) |=> state == LAMP_OFF)
		else $error("door lamp not ended");
	a_pwm_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!lamp_lit |=> !cabin_lamp_o) else $error("lamp lit while off");
	c_door_open: cover property (@(posedge clk_i) state == LAMP_DOOR_OPEN);
	c_rearm: cover property (@(posedge clk_i) state == LAMP_REARM);
	c_slot: cover property (@(posedge clk_i) slot_on);
	c_dim: cover property (@(posedge clk_i) state == LAMP_TIMED && level == BRIGHT_DIM);
endmodule : cabin_light_timer_control
`default_nettype wire

/* cabin_switch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cabin_switch_model #(
	parameter int unsigned DOORS = 5
) (
	// clock
	input  wire logic             clk_i,
	// lamp drive seen by the lamp driver
	input  wire logic             cabin_lamp_i,
	// switch lines to the controller
	output logic                  ignition_on_o,
	output logic [DOORS-1:0]      door_open_o,
	output logic                  key_inserted_o,
	output logic                  knob_unlocked_o,
	output logic                  keyless_lock_o,
	output logic                  parking_lamp_state_o
);
	// switch positions at power up: doors shut, knob unlocked
	initial begin
		ignition_on_o = 1'b0;
		door_open_o = '0;
		key_inserted_o = 1'b0;
		knob_unlocked_o = 1'b1;
		keyless_lock_o = 1'b0;
		parking_lamp_state_o = 1'b0;
	end
	// move all switches but the keyless lock together, off the sampling edge
	task automatic set_sw(input logic [DOORS-1:0] d, input logic ign, input logic key, input logic knob,
		input logic park);
		@(negedge clk_i);
		door_open_o = d;
		ignition_on_o = ign;
		key_inserted_o = key;
		knob_unlocked_o = knob;
		parking_lamp_state_o = park;
	endtask : set_sw
	// keyless lock command, a few clocks wide
	task automatic lock_pulse();
		@(negedge clk_i);
		keyless_lock_o = 1'b1;
		repeat (4) @(negedge clk_i);
		keyless_lock_o = 1'b0;
	endtask : lock_pulse
	// lamp driver view: high clocks over one pwm period
	task automatic duty(output logic [7:0] n);
		n = 8'h00;
		repeat (100) begin
			@(posedge clk_i);
			#1;
			if (cabin_lamp_i === 1'b1) n = n + 8'h01;
		end
	endtask : duty
endmodule : cabin_switch_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cabin_light_pkg::*;
	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       ign, key, knob, kl, park, lamp, slot, ind;
	logic [4:0] doors;
	logic [6:0] level;
	logic [7:0] d;
	int         err_total = 0;
	int         checks = 0;
	int         cyc = 0;
	// 50 MHz clock and hang guard
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total = err_total + 1;
			test_done();
		end
	end
	cabin_switch_model #(.DOORS(5)) sw (.clk_i(clk_i), .cabin_lamp_i(lamp), .ignition_on_o(ign),
		.door_open_o(doors), .key_inserted_o(key), .knob_unlocked_o(knob), .keyless_lock_o(kl),
		.parking_lamp_state_o(park));
	cabin_light_timer_control #(.TICK_DIV(2), .DOOR_COUNT(5)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.ignition_on_i(ign), .door_open_i(doors), .key_inserted_i(key), .knob_unlocked_i(knob),
		.keyless_lock_i(kl), .parking_lamp_state_i(park), .cabin_lamp_o(lamp), .cabin_level_o(level),
		.key_slot_lamp_o(slot), .indirect_lamp_o(ind));
	// compare and count
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks = checks + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// let debounce and output flops settle
	task automatic settle();
		repeat (80) @(posedge clk_i);
		#1;
	endtask : settle
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	// main sequence
	initial begin
		repeat (16) @(negedge clk_i);
		rst_n_i = 1'b1;
		sw.set_sw(5'h00, 1'b0, 1'b0, 1'b1, 1'b1);
		settle();
		chk("indirect on", 8'h01, {7'h00, ind});
		sw.set_sw(5'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		settle();
		chk("indirect off", 8'h00, {7'h00, ind});
		sw.set_sw(5'h01, 1'b0, 1'b0, 1'b1, 1'b0);
		settle();
		chk("door open level", {1'b0, BRIGHT_FULL}, {1'b0, level});
		chk("slot on", 8'h01, {7'h00, slot});
		sw.set_sw(5'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		settle();
		chk("door close level", {1'b0, BRIGHT_DIM}, {1'b0, level});
		sw.duty(d);
		chk("pwm duty", {1'b0, BRIGHT_DIM}, d);
		repeat (29400) @(posedge clk_i);
		#1;
		chk("dim held", {1'b0, BRIGHT_DIM}, {1'b0, level});
		chk("slot held", 8'h01, {7'h00, slot});
		repeat (1000) @(posedge clk_i);
		#1;
		chk("dim expired", 8'h00, {1'b0, level});
		chk("slot expired", 8'h00, {7'h00, slot});
		sw.set_sw(5'h00, 1'b0, 1'b1, 1'b1, 1'b0);
		settle();
		sw.set_sw(5'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		settle();
		chk("key out level", {1'b0, BRIGHT_FULL}, {1'b0, level});
		sw.set_sw(5'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		settle();
		chk("knob lock cancel", 8'h00, {1'b0, level});
		sw.set_sw(5'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		settle();
		chk("unlock level", {1'b0, BRIGHT_FULL}, {1'b0, level});
		sw.set_sw(5'h00, 1'b1, 1'b0, 1'b1, 1'b0);
		settle();
		chk("ignition cancel", 8'h00, {1'b0, level});
		sw.set_sw(5'h01, 1'b0, 1'b0, 1'b1, 1'b0);
		settle();
		sw.set_sw(5'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		settle();
		chk("slot after close", 8'h01, {7'h00, slot});
		sw.lock_pulse();
		settle();
		chk("slot keyless off", 8'h00, {7'h00, slot});
		sw.set_sw(5'h01, 1'b0, 1'b0, 1'b1, 1'b0);
		settle();
		chk("slot reopen", 8'h01, {7'h00, slot});
		sw.set_sw(5'h01, 1'b1, 1'b0, 1'b1, 1'b0);
		settle();
		chk("slot ignition off", 8'h00, {7'h00, slot});
		sw.set_sw(5'h01, 1'b0, 1'b0, 1'b1, 1'b0);
		settle();
		chk("slot ignition back", 8'h01, {7'h00, slot});
		test_done();
	end
endmodule : tb_top
`default_nettype wire
